// ---- hdl/nep_map.svh ----
`ifndef NEP_MAP_SVH
`define NEP_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define NEP_OFS_INDEX       16'h302A
`define NEP_OFS_PROT        16'h3029
`define NEP_OFS_COMMAND_OBJECT_WORD_HI     16'h302D
`define NEP_OFS_COMMAND_OBJECT_WORD_LO     16'h302B
`define NEP_OFS_OPTION      16'h302C
`define NEP_OFS_STATUS      16'h302E
`define NEP_OFS_MASK        16'h302F
`define NEP_OFS_EE_REQ      16'h3030
`define NEP_OFS_EE_ADDR     16'h3031
// ----------------------------------------
// Field positions
// ----------------------------------------
`define NEP_PROT_OPEN_BIT   7
`define NEP_STAT_VIOL_BIT   0
`define NEP_STAT_BLKREF_BIT 1
`define NEP_STAT_DONE_BIT   2
`define NEP_REQ_GO_BIT      0
`define NEP_REQ_ERASE_BIT   1
`define NEP_REQ_BLOCK_BIT   2
// ----------------------------------------
// Configuration field addresses and reset values
// ----------------------------------------
`define NEP_CFG_PROT_ADDR   16'hFF7D
`define NEP_CFG_OPT_ADDR    16'hFF7E
`define NEP_PROT_SAFE       8'h07
`define NEP_COMMAND_OBJECT_WORD_WORDS      6
`endif

// ---- hdl/nep_pkg.sv ----
package nep_pkg;
    typedef enum logic [1:0] {
        NEP_LD_PROT = 2'b00,
        NEP_LD_OPT  = 2'b01,
        NEP_LD_DONE = 2'b11
    } nep_load_t;
endpackage : nep_pkg

// ---- hdl/nep_cfg_loader.sv ----
`timescale 1ns/1ps
`include "nep_map.svh"
module nep_cfg_loader (
    input  wire logic        clk,
    input  wire logic        rst,
    output logic [15:0]      cfg_addr,
    input  wire logic [7:0]  cfg_data,
    output logic             load_prot,
    output logic             load_opt,
    output logic             done
);
    nep_pkg::nep_load_t state_q;
    nep_pkg::nep_load_t state_d;

    always_comb begin
        state_d   = state_q;
        load_prot = 1'b0;
        load_opt  = 1'b0;
        cfg_addr  = `NEP_CFG_PROT_ADDR;
        case (state_q)
            nep_pkg::NEP_LD_PROT: begin
                load_prot = 1'b1;
                state_d   = nep_pkg::NEP_LD_OPT;
            end
            nep_pkg::NEP_LD_OPT: begin
                cfg_addr = `NEP_CFG_OPT_ADDR;
                load_opt = 1'b1;
                state_d  = nep_pkg::NEP_LD_DONE;
            end
            nep_pkg::NEP_LD_DONE: state_d = nep_pkg::NEP_LD_DONE;
            default: state_d = nep_pkg::NEP_LD_PROT;
        endcase
    end

    assign done = (state_q == nep_pkg::NEP_LD_DONE);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= nep_pkg::NEP_LD_PROT;
        end else begin
            state_q <= state_d;
        end
    end
endmodule : nep_cfg_loader

// ---- hdl/nep_sector_check.sv ----
`timescale 1ns/1ps
module nep_sector_check #(
    parameter int SECTORS   = 8,
    parameter int ADDR_W    = 8
) (
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              open_bit,
    input  wire logic [2:0]        size,
    output logic                   addr_prot,
    output logic                   any_prot
);
    // ----------------------------------------
    // Sector decode
    // ----------------------------------------
    localparam int SEC_W = $clog2(SECTORS);
    initial begin
        if (SECTORS != 8 || ADDR_W < SEC_W) $error("nep_sector_check: unsupported geometry");
    end
    logic [SECTORS-1:0] prot_map;
    logic [SEC_W-1:0]   sec;
    assign sec = addr[ADDR_W-1 -: SEC_W];
    // Size n protects the top n+1 sectors, so larger values cover more
    genvar g;
    generate
        for (g = 0; g < SECTORS; g = g + 1) begin : g_sec
            assign prot_map[g] = !open_bit && (g >= (SECTORS - 1 - int'(size)));
        end
    endgenerate
    assign addr_prot = prot_map[sec];
    assign any_prot  = |prot_map;
endmodule : nep_sector_check

// ---- hdl/nep_regs.sv ----
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "nep_map.svh"
// What this block does
// - Protection writes can only add protection; a loosening field in a write is ignored.
// - Open bit only goes 1 to 0; size only accepts larger values.
// - While open bit is set, size is ignored for protection decisions.
// - Reset loads open bit and size from config byte at 0xFF7D.
// - Program or erase to protected location is refused and sets violation flag.
// - Block erase refused while any sector is protected.
// - Open bit 1 disables protection; 0 protects range set by size.
// - Protection register bits 6 to 3 always read zero.
// - Protection size field is exposed in the protection register.
// - Six 16-bit command words chosen by index, accessed bytewise.
// - High register is bits 15:8, low register bits 7:0 of word.
// - Reset loads all eight option bits from config byte at 0xFF7E.
module nep_regs #(
    parameter int EE_ADDR_W = 8
) (
    input  wire logic                 CLOCK,
    input  wire logic                 RST,
    input  wire logic [15:0]          ADDR,
    input  wire logic [7:0]           WDATA,
    input  wire logic                 WR,
    input  wire logic                 RD,
    output logic      [7:0]           RDATA,
    output logic      [15:0]          CFG_ADDR,
    input  wire logic [7:0]           CFG_DATA,
    output logic                      EE_OP_GO,
    output logic                      EE_OP_ERASE,
    output logic                      EE_OP_BLOCK,
    output logic      [EE_ADDR_W-1:0] EE_OP_ADDR,
    output logic                      IRQ
);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    initial begin
        if (EE_ADDR_W < 3 || EE_ADDR_W > 8) $error("nep_regs: EE_ADDR_W out of range");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0]           prot_q,    prot_d;
    logic [7:0]           opt_q,     opt_d;
    logic [2:0]           idx_q,     idx_d;
    logic [15:0]          command_object_word_q [`NEP_COMMAND_OBJECT_WORD_WORDS];
    logic [15:0]          command_object_word_d [`NEP_COMMAND_OBJECT_WORD_WORDS];
    logic [2:0]           stat_q,    stat_d;
    logic [2:0]           mask_q,    mask_d;
    logic [2:0]           req_q,     req_d;
    logic [EE_ADDR_W-1:0] eaddr_q,   eaddr_d;
    logic [7:0]           rdata_q,   rdata_d;
    logic                 go_q,      go_d;
    logic                 erase_q,   erase_d;
    logic                 block_q,   block_d;
    logic [EE_ADDR_W-1:0] op_addr_q, op_addr_d;
    logic                 irq_q,     irq_d;

    logic                 load_prot;
    logic                 load_opt;
    logic                 load_done;
    logic                 addr_prot;
    logic                 any_prot;
    logic                 eff_open;
    logic [2:0]           eff_size;
    logic [15:0]          cfg_addr;
    logic [15:0]          cfg_addr_d;

    nep_cfg_loader u_loader (
        .clk       (CLOCK),
        .rst       (RST),
        .cfg_addr  (cfg_addr),
        .cfg_data  (CFG_DATA),
        .load_prot (load_prot),
        .load_opt  (load_opt),
        .done      (load_done)
    );

    // The registered address must already name the byte the loader takes next
    assign cfg_addr_d = load_prot ? `NEP_CFG_OPT_ADDR : cfg_addr;

    // Until the load finishes every sector counts as protected
    assign eff_open = load_done ? prot_q[`NEP_PROT_OPEN_BIT] : 1'b0;
    assign eff_size = load_done ? prot_q[2:0] : 3'h7;

    nep_sector_check #(
        .SECTORS (8),
        .ADDR_W  (EE_ADDR_W)
    ) u_check (
        .addr      (eaddr_q),
        .open_bit  (eff_open),
        .size      (eff_size),
        .addr_prot (addr_prot),
        .any_prot  (any_prot)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic        command_object_word_wr_hi;
    logic        command_object_word_wr_lo;
    logic        idx_ok;
    logic        refuse;
    logic        launch;
    logic [2:0]  ev;
    logic [15:0] sel_word;

    assign idx_ok     = (idx_q < 3'(`NEP_COMMAND_OBJECT_WORD_WORDS));
    assign command_object_word_wr_hi = WR && (ADDR == `NEP_OFS_COMMAND_OBJECT_WORD_HI) && idx_ok;
    assign command_object_word_wr_lo = WR && (ADDR == `NEP_OFS_COMMAND_OBJECT_WORD_LO) && idx_ok;
    assign sel_word   = idx_ok ? command_object_word_q[idx_q] : 16'h0000;
    assign launch     = req_q[`NEP_REQ_GO_BIT];
    // Block erase needs the whole array open; single ops need their sector open
    assign refuse     = req_q[`NEP_REQ_BLOCK_BIT] ? any_prot : addr_prot;

    always_comb begin
        prot_d    = prot_q;
        opt_d     = opt_q;
        idx_d     = idx_q;
        stat_d    = stat_q;
        mask_d    = mask_q;
        req_d     = 3'h0;
        eaddr_d   = eaddr_q;
        go_d      = 1'b0;
        erase_d   = erase_q;
        block_d   = block_q;
        op_addr_d = op_addr_q;
        rdata_d   = 8'h00;
        ev        = 3'h0;
        for (int i = 0; i < `NEP_COMMAND_OBJECT_WORD_WORDS; i++) begin
            command_object_word_d[i] = command_object_word_q[i];
        end

        if (load_prot) begin
            prot_d = {CFG_DATA[`NEP_PROT_OPEN_BIT], 4'h0, CFG_DATA[2:0]};
        end
        if (load_opt) begin
            opt_d = CFG_DATA;
        end

        if (WR && load_done) begin
            case (ADDR)
                `NEP_OFS_PROT: begin
                    // Each field tightens on its own; a loosening field is dropped
                    if (prot_q[`NEP_PROT_OPEN_BIT] && !WDATA[`NEP_PROT_OPEN_BIT]) begin
                        prot_d[`NEP_PROT_OPEN_BIT] = 1'b0;
                    end
                    if (WDATA[2:0] > prot_q[2:0]) begin
                        prot_d[2:0] = WDATA[2:0];
                    end
                end
                `NEP_OFS_INDEX:   idx_d   = WDATA[2:0];
                `NEP_OFS_MASK:    mask_d  = WDATA[2:0];
                `NEP_OFS_EE_ADDR: eaddr_d = WDATA[EE_ADDR_W-1:0];
                `NEP_OFS_EE_REQ:  req_d   = WDATA[2:0];
                default: ;
            endcase
        end
        if (command_object_word_wr_hi) begin
            command_object_word_d[idx_q][15:8] = WDATA;
        end
        if (command_object_word_wr_lo) begin
            command_object_word_d[idx_q][7:0] = WDATA;
        end

        if (launch) begin
            if (refuse) begin
                ev[`NEP_STAT_VIOL_BIT]   = 1'b1;
                ev[`NEP_STAT_BLKREF_BIT] = req_q[`NEP_REQ_BLOCK_BIT];
            end else begin
                go_d                   = 1'b1;
                erase_d                = req_q[`NEP_REQ_ERASE_BIT];
                block_d                = req_q[`NEP_REQ_BLOCK_BIT];
                op_addr_d              = eaddr_q;
                ev[`NEP_STAT_DONE_BIT] = 1'b1;
            end
        end

        if (RD) begin
            case (ADDR)
                `NEP_OFS_PROT:    rdata_d = {prot_q[7], 4'h0, prot_q[2:0]};
                `NEP_OFS_INDEX:   rdata_d = {5'h00, idx_q};
                `NEP_OFS_COMMAND_OBJECT_WORD_HI: rdata_d = sel_word[15:8];
                `NEP_OFS_COMMAND_OBJECT_WORD_LO: rdata_d = sel_word[7:0];
                `NEP_OFS_OPTION:  rdata_d = opt_q;
                `NEP_OFS_STATUS:  rdata_d = {5'h00, stat_q};
                `NEP_OFS_MASK:    rdata_d = {5'h00, mask_q};
                `NEP_OFS_EE_ADDR: rdata_d = 8'(eaddr_q);
                default:          rdata_d = 8'h00;
            endcase
            // Read clears status, but an event in the same cycle survives
            if (ADDR == `NEP_OFS_STATUS) begin
                stat_d = 3'h0;
            end
        end
        stat_d = stat_d | ev;
        irq_d  = |(stat_d & mask_d);
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            prot_q    <= `NEP_PROT_SAFE;
            opt_q     <= 8'h00;
            idx_q     <= 3'h0;
            stat_q    <= 3'h0;
            mask_q    <= 3'h0;
            req_q     <= 3'h0;
            eaddr_q   <= '0;
            rdata_q   <= 8'h00;
            go_q      <= 1'b0;
            erase_q   <= 1'b0;
            block_q   <= 1'b0;
            op_addr_q <= '0;
            irq_q     <= 1'b0;
            CFG_ADDR  <= `NEP_CFG_PROT_ADDR;
            for (int i = 0; i < `NEP_COMMAND_OBJECT_WORD_WORDS; i++) begin
                command_object_word_q[i] <= 16'h0000;
            end
        end else begin
            prot_q    <= prot_d;
            opt_q     <= opt_d;
            idx_q     <= idx_d;
            stat_q    <= stat_d;
            mask_q    <= mask_d;
            req_q     <= req_d;
            eaddr_q   <= eaddr_d;
            rdata_q   <= rdata_d;
            go_q      <= go_d;
            erase_q   <= erase_d;
            block_q   <= block_d;
            op_addr_q <= op_addr_d;
            irq_q     <= irq_d;
            CFG_ADDR  <= cfg_addr_d;
            for (int i = 0; i < `NEP_COMMAND_OBJECT_WORD_WORDS; i++) begin
                command_object_word_q[i] <= command_object_word_d[i];
            end
        end
    end

    assign RDATA       = rdata_q;
    assign EE_OP_GO    = go_q;
    assign EE_OP_ERASE = erase_q;
    assign EE_OP_BLOCK = block_q;
    assign EE_OP_ADDR  = op_addr_q;
    assign IRQ         = irq_q;
endmodule : nep_regs

// ---- sim/nep_regs_sva.sv ----
`timescale 1ns/1ps
`include "nep_map.svh"
module nep_regs_sva #(
    parameter int EE_ADDR_W = 8
) (
    input wire logic                 CLOCK,
    input wire logic                 RST,
    input wire logic [15:0]          ADDR,
    input wire logic [7:0]           WDATA,
    input wire logic                 WR,
    input wire logic                 RD,
    input wire logic [7:0]           RDATA,
    input wire logic [15:0]          CFG_ADDR,
    input wire logic [7:0]           CFG_DATA,
    input wire logic                 EE_OP_GO,
    input wire logic                 EE_OP_ERASE,
    input wire logic                 EE_OP_BLOCK,
    input wire logic [EE_ADDR_W-1:0] EE_OP_ADDR,
    input wire logic                 IRQ
);
// ----------------------------------------
// Shadow of protection seen on reads
// ----------------------------------------
logic       prot_rd_q;
logic       closed_q;
logic [2:0] size_q;
always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
        prot_rd_q <= 1'b0;
        closed_q  <= 1'b0;
        size_q    <= 3'h0;
    end else begin
        prot_rd_q <= RD && ADDR == `NEP_OFS_PROT;
        closed_q  <= closed_q || (prot_rd_q && !RDATA[7]);
        size_q    <= prot_rd_q ? RDATA[2:0] : size_q;
    end
end
// ----------------------------------------
// Properties
// ----------------------------------------
default clocking cb @(posedge CLOCK); endclocking
default disable iff (RST);
sequence s_cfg_walk;
    CFG_ADDR == `NEP_CFG_PROT_ADDR ##1 CFG_ADDR == `NEP_CFG_OPT_ADDR;
endsequence
sequence s_go_req;
    WR && ADDR == `NEP_OFS_EE_REQ && WDATA[`NEP_REQ_GO_BIT];
endsequence
property p_rd_idle; !$past(RD) |-> RDATA == 8'h00; endproperty
property p_resv; prot_rd_q |-> RDATA[6:3] == 4'h0; endproperty
property p_open; prot_rd_q && closed_q |-> !RDATA[7]; endproperty
property p_size; prot_rd_q |-> RDATA[2:0] >= size_q; endproperty
property p_cfg; $fell(RST) |-> s_cfg_walk; endproperty
property p_go_cause; EE_OP_GO |-> $past(WR && ADDR == `NEP_OFS_EE_REQ, 2); endproperty
property p_go_kind;
    s_go_req ##2 EE_OP_GO |-> EE_OP_ERASE == $past(WDATA[1], 2) && EE_OP_BLOCK == $past(WDATA[2], 2);
endproperty
property p_go_pulse; EE_OP_GO && !$past(WR && ADDR == `NEP_OFS_EE_REQ) |=> !EE_OP_GO; endproperty
property p_addr_hold; $changed(EE_OP_ADDR) |-> EE_OP_GO; endproperty
property p_irq_clear; RD && ADDR == `NEP_OFS_STATUS |-> ##2 !IRQ; endproperty
a_rd_idle: assert property (p_rd_idle) else $error("read data without a read");
a_resv: assert property (p_resv) else $error("reserved protection bits set");
a_open: assert property (p_open) else $error("protection reopened");
a_size: assert property (p_size) else $error("protection size shrank");
a_cfg: assert property (p_cfg) else $error("config load order wrong");
a_go_cause: assert property (p_go_cause) else $error("operation without request");
a_go_kind: assert property (p_go_kind) else $error("operation kind wrong");
a_go_pulse: assert property (p_go_pulse) else $error("go longer than one cycle");
a_addr_hold: assert property (p_addr_hold) else $error("op address moved without go");
a_irq_clear: assert property (p_irq_clear) else $error("interrupt stays after status read");
endmodule : nep_regs_sva

bind nep_regs nep_regs_sva #(.EE_ADDR_W(EE_ADDR_W)) nep_regs_sva_i (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CFG_ADDR(CFG_ADDR), .CFG_DATA(CFG_DATA),
    .EE_OP_GO(EE_OP_GO), .EE_OP_ERASE(EE_OP_ERASE), .EE_OP_BLOCK(EE_OP_BLOCK), .EE_OP_ADDR(EE_OP_ADDR), .IRQ(IRQ));

// ---- sim/nep_regs_tb.sv ----
`timescale 1ns/1ps
`include "nep_map.svh"
module nep_regs_tb;
logic        CLOCK;
logic        RST;
logic [15:0] ADDR;
logic [7:0]  WDATA;
logic        WR;
logic        RD;
logic [7:0]  RDATA;
logic [15:0] CFG_ADDR;
logic [7:0]  CFG_DATA;
logic        EE_OP_GO;
logic        EE_OP_ERASE;
logic        EE_OP_BLOCK;
logic [7:0]  EE_OP_ADDR;
logic        IRQ;
logic [7:0]  opt_v;
logic [7:0]  hi_v [6];
logic [7:0]  lo_v [6];
logic [7:0]  exp_q [$];
logic [9:0]  op_q [$];
logic        rd_seen;
int          miscompares;
int          cmp_count;
// Reserved bits set on purpose: they must not reach the register
localparam logic [7:0] PROT_CFG = 8'hFA;
// Off the two config addresses the flash returns junk, never the last byte
assign CFG_DATA = (CFG_ADDR === `NEP_CFG_PROT_ADDR) ? PROT_CFG :
                  (CFG_ADDR === `NEP_CFG_OPT_ADDR) ? opt_v : ~opt_v;
nep_regs #(.EE_ADDR_W(8)) nep_regs_i (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .CFG_ADDR(CFG_ADDR), .CFG_DATA(CFG_DATA), .EE_OP_GO(EE_OP_GO), .EE_OP_ERASE(EE_OP_ERASE),
    .EE_OP_BLOCK(EE_OP_BLOCK), .EE_OP_ADDR(EE_OP_ADDR), .IRQ(IRQ));
always #20 CLOCK = ~CLOCK;
// ----------------------------------------
// Tasks
// ----------------------------------------
task automatic chk(input string n, input logic [9:0] s, input logic [9:0] e);
    cmp_count++;
    if (s !== e) begin
        miscompares++;
        $display("BAD %s exp %h got %h", n, e, s);
    end
endtask : chk
task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    WR    <= w;
    RD    <= !w;
    ADDR  <= a;
    WDATA <= d;
    @(posedge CLOCK);
endtask : bus
task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
endtask : rd
task automatic idle(input int n);
    WR <= 1'b0;
    RD <= 1'b0;
    repeat (n) @(posedge CLOCK);
endtask : idle
// Mask is 0x01, so only the violation flag may raise the interrupt
task automatic op(input logic [7:0] a, input logic [2:0] r, input logic [7:0] st, input logic go);
    bus(1'b1, `NEP_OFS_EE_ADDR, a);
    bus(1'b1, `NEP_OFS_EE_REQ, {5'h00, r});
    if (go) op_q.push_back({r[1], r[2], a});
    idle(4);
    chk("irq", {9'h000, IRQ}, {9'h000, st[`NEP_STAT_VIOL_BIT]});
    rd(`NEP_OFS_STATUS, st);
endtask : op
task automatic finish_test;
    if (exp_q.size() != 0 || op_q.size() != 0) miscompares++;
    if (miscompares == 0 && cmp_count > 0) begin
        $display("bench passed");
    end else begin
        $display("bench failed");
    end
    $finish;
endtask : finish_test
// ----------------------------------------
// Output watcher
// ----------------------------------------
always @(posedge CLOCK) begin
    if (rd_seen) chk("rdata", {2'b00, RDATA}, {2'b00, exp_q.pop_front()});
    if (EE_OP_GO === 1'b1) chk("op", {EE_OP_ERASE, EE_OP_BLOCK, EE_OP_ADDR}, op_q.size() > 0 ? op_q.pop_front() : 10'h3FF);
    rd_seen <= (RD === 1'b1);
end
initial begin
    repeat (3000) @(posedge CLOCK);
    miscompares++;
    finish_test;
end
// ----------------------------------------
// Main sequence
// ----------------------------------------
initial begin
    CLOCK = 1'b0;
    RST = 1'b1;
    ADDR = 16'h0000;
    WDATA = 8'h00;
    WR = 1'b0;
    RD = 1'b0;
    rd_seen = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    void'($urandom(74));
    opt_v = 8'($urandom);
    for (int i = 0; i < 6; i++) begin
        hi_v[i] = 8'($urandom);
        lo_v[i] = 8'($urandom);
    end
    repeat (12) @(posedge CLOCK);
    RST <= 1'b0;
    idle(4);
    rd(`NEP_OFS_PROT, 8'h82);
    rd(`NEP_OFS_OPTION, opt_v);
    bus(1'b1, `NEP_OFS_MASK, 8'h01);
    op(8'hFF, 3'b001, 8'h04, 1'b1);
    op(8'hE0, 3'b111, 8'h04, 1'b1);
    bus(1'b1, `NEP_OFS_PROT, 8'h00);
    rd(`NEP_OFS_PROT, 8'h02);
    bus(1'b1, `NEP_OFS_PROT, 8'h80);
    bus(1'b1, `NEP_OFS_PROT, 8'h01);
    rd(`NEP_OFS_PROT, 8'h02);
    bus(1'b1, `NEP_OFS_PROT, 8'h85);
    rd(`NEP_OFS_PROT, 8'h05);
    op(8'h3F, 3'b001, 8'h04, 1'b1);
    op(8'h40, 3'b011, 8'h01, 1'b0);
    op(8'h00, 3'b111, 8'h03, 1'b0);
    op(8'h20, 3'b001, 8'h04, 1'b1);
    bus(1'b1, `NEP_OFS_PROT, 8'h07);
    op(8'h00, 3'b001, 8'h01, 1'b0);
    for (int i = 0; i < 6; i++) begin
        bus(1'b1, `NEP_OFS_INDEX, 8'(i));
        bus(1'b1, `NEP_OFS_COMMAND_OBJECT_WORD_HI, hi_v[i]);
        bus(1'b1, `NEP_OFS_COMMAND_OBJECT_WORD_LO, lo_v[i]);
    end
    for (int i = 0; i < 6; i++) begin
        bus(1'b1, `NEP_OFS_INDEX, 8'(i));
        rd(`NEP_OFS_COMMAND_OBJECT_WORD_HI, hi_v[i]);
        rd(`NEP_OFS_COMMAND_OBJECT_WORD_LO, lo_v[i]);
    end
    bus(1'b1, `NEP_OFS_INDEX, 8'h06);
    bus(1'b1, `NEP_OFS_COMMAND_OBJECT_WORD_HI, 8'hFF);
    rd(`NEP_OFS_COMMAND_OBJECT_WORD_HI, 8'h00);
    rd(16'h3040, 8'h00);
    idle(3);
    finish_test;
end
endmodule : nep_regs_tb
